// [rtl/chan_regs_params.svh]
// Purpose: Register offsets, codes and reset values for the channel control registers.
// Assumes: Offsets are the register numbers used on the register port.
// Notes: Definitions only.
`ifndef CHAN_REGS_PARAMS_SVH
`define CHAN_REGS_PARAMS_SVH
`define REG_BOARD_COMMAND 32'h0000_0064
`define REG_CHANNEL_ENABLE_MASK 32'h0000_2af8
`define REG_ENABLED_CHANNEL_COUNT 32'h0000_2af9
`define CARD_RESET_COMMAND 32'h0000_0001
`define CHAN_MASK_DEFAULT 8'h01
`define CHAN_COUNT_DEFAULT 4'h1
`define HALF_LOW_MASK 8'h0f
`define HALF_HIGH_MASK 8'hf0
`define INSTALLED_DEFAULT 4'h8
`endif

// [rtl/chan_regs_pkg.sv]
// Purpose: Types shared by the channel control register bank.
// Assumes: 32-bit register port.
// Notes: Holds types only.
package chan_regs_pkg;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [31:0] addr;
      logic [31:0] wdata;
   } reg_req_s;
   typedef struct packed {
      logic ack;
      logic value_error;
      logic [31:0] rdata;
   } reg_rsp_s;
endpackage : chan_regs_pkg

// [rtl/channel_enable_and_reset_regs.sv]
// Purpose: Command, channel enable and channel count registers of an acquisition board.
// Assumes: One request per cycle at most, answered on the next edge.
// Notes: The card reset command restores every register as power-on reset does.
`timescale 1ns/1ps
`include "chan_regs_params.svh"
module channel_enable_and_reset_regs #(
   parameter logic [3:0] INSTALLED_CHANNELS = `INSTALLED_DEFAULT
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input chan_regs_pkg::reg_req_s req,
   output chan_regs_pkg::reg_rsp_s rsp,
   input wire logic run_start,
   output logic [7:0] run_channel_mask,
   output logic [3:0] run_channel_count,
   output logic memory_valid,
   output logic trig_out_enable,
   output logic clk_out_enable,
   input wire logic memory_written,
   input wire logic trig_out_request,
   input wire logic clk_out_request
);
   function automatic logic [3:0] popcount8(input logic [7:0] m);
      logic [3:0] c;
      c = 4'h0;
      for (int i = 0; i < 8; i++) begin
         c = c + {3'h0, m[i]};
      end
      return c;
   endfunction : popcount8

   logic [7:0] mask_reg;
   logic [7:0] mask_next;
   logic [3:0] count_reg;
   logic soft_reset_reg;
   logic soft_reset_next;
   logic [7:0] run_mask_reg;
   logic [3:0] run_count_reg;
   logic mem_valid_reg;
   logic trig_en_reg;
   logic clk_en_reg;
   chan_regs_pkg::reg_rsp_s rsp_reg;
   chan_regs_pkg::reg_rsp_s rsp_next;

   wire sel_cmd = req.addr == `REG_BOARD_COMMAND;
   wire sel_mask = req.addr == `REG_CHANNEL_ENABLE_MASK;
   wire sel_count = req.addr == `REG_ENABLED_CHANNEL_COUNT;
   wire [7:0] wmask = req.wdata[7:0];
   wire [3:0] wcount = popcount8(wmask);
   wire [3:0] low_count = popcount8(wmask & `HALF_LOW_MASK);
   wire [3:0] high_count = popcount8(wmask & `HALF_HIGH_MASK);
   wire [7:0] inst_mask = (8'h01 << INSTALLED_CHANNELS[3:0]) - 8'h01;
   wire in_range = (INSTALLED_CHANNELS[3] ? 1'b1 : ((wmask & ~inst_mask) == 8'h00))
      && (req.wdata[31:8] == 24'h000000);
   // One channel, two channels, four channels, eight channels.
   wire four_ok = (INSTALLED_CHANNELS >= 4'h4)
      && ((low_count == 4'h4) || (high_count == 4'h4)
      || ((low_count == 4'h2) && (high_count == 4'h2)));
   wire mask_ok = in_range && ((wcount == 4'h1) || (wcount == 4'h2)
      || ((wcount == 4'h4) && four_ok) || (wcount == 4'h8));
   wire mask_bad = req.wr && sel_mask && !mask_ok;
   assign soft_reset_next = req.wr && sel_cmd && (req.wdata == `CARD_RESET_COMMAND);
   assign mask_next = (req.wr && sel_mask && mask_ok) ? wmask : mask_reg;

   always_comb begin
      rsp_next = '0;
      rsp_next.ack = req.wr || req.rd;
      rsp_next.value_error = mask_bad;
      if (req.rd && sel_mask) begin
         rsp_next.rdata = {24'h000000, mask_reg};
      end else if (req.rd && sel_count) begin
         rsp_next.rdata = {28'h0000000, count_reg};
      end
   end

   // Same reset path for power-on and command. defaults. outputs off.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         soft_reset_reg <= 1'b0;
         mask_reg <= `CHAN_MASK_DEFAULT;
         count_reg <= `CHAN_COUNT_DEFAULT;
         run_mask_reg <= `CHAN_MASK_DEFAULT;
         run_count_reg <= `CHAN_COUNT_DEFAULT;
         mem_valid_reg <= 1'b0;
         trig_en_reg <= 1'b0;
         clk_en_reg <= 1'b0;
         rsp_reg <= '0;
      end else if (soft_reset_reg) begin
         soft_reset_reg <= 1'b0;
         mask_reg <= `CHAN_MASK_DEFAULT;
         count_reg <= `CHAN_COUNT_DEFAULT;
         run_mask_reg <= `CHAN_MASK_DEFAULT;
         run_count_reg <= `CHAN_COUNT_DEFAULT;
         mem_valid_reg <= 1'b0;
         trig_en_reg <= 1'b0;
         clk_en_reg <= 1'b0;
         rsp_reg <= '0;
      end else begin
         soft_reset_reg <= soft_reset_next;
         mask_reg <= mask_next;
         count_reg <= popcount8(mask_next);
         // Latch at run start. count sets memory split.
         if (run_start) begin
            run_mask_reg <= mask_reg;
            run_count_reg <= count_reg;
         end
         mem_valid_reg <= mem_valid_reg || memory_written;
         trig_en_reg <= trig_out_request;
         clk_en_reg <= clk_out_request;
         rsp_reg <= rsp_next;
      end
   end

   assign rsp = rsp_reg;
   assign run_channel_mask = run_mask_reg;
   assign run_channel_count = run_count_reg;
   assign memory_valid = mem_valid_reg;
   assign trig_out_enable = trig_en_reg;
   assign clk_out_enable = clk_en_reg;

   property p_count_tracks;
      @(posedge ref_clk) disable iff (!rstn)
      count_reg == popcount8(mask_reg);
   endproperty
   a_count_tracks: assert property (p_count_tracks) else $error("count differs from mask");

   property p_reject_keeps;
      @(posedge ref_clk) disable iff (!rstn)
      (mask_bad && !soft_reset_reg) |=> (mask_reg == $past(mask_reg) && rsp.value_error);
   endproperty
   a_reject_keeps: assert property (p_reject_keeps) else $error("rejected mask changed");

   property p_reset_cmd;
      @(posedge ref_clk) disable iff (!rstn)
      (soft_reset_next && !soft_reset_reg) |=> ##1
      (mask_reg == `CHAN_MASK_DEFAULT && !memory_valid && !trig_out_enable && !clk_out_enable);
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("card reset incomplete");

   property p_three_bad;
      @(posedge ref_clk) disable iff (!rstn)
      (req.wr && sel_mask && wcount == 4'h3 && !soft_reset_reg) |=> rsp.value_error;
   endproperty
   a_three_bad: assert property (p_three_bad) else $error("three channel mask accepted");

   property p_run_hold;
      @(posedge ref_clk) disable iff (!rstn)
      (!run_start && !soft_reset_reg) |=> $stable(run_channel_mask);
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("run mask changed mid run");

   property p_single_ok;
      @(posedge ref_clk) disable iff (!rstn)
      (req.wr && sel_mask && wcount == 4'h1 && in_range && !soft_reset_reg) |=>
      (mask_reg == $past(wmask));
   endproperty
   a_single_ok: assert property (p_single_ok) else $error("single channel refused");

   property p_pair_ok;
      @(posedge ref_clk) disable iff (!rstn)
      (req.wr && sel_mask && wcount == 4'h2 && in_range && !soft_reset_reg) |=> !rsp.value_error;
   endproperty
   a_pair_ok: assert property (p_pair_ok) else $error("pair refused");

   property p_four_rule;
      @(posedge ref_clk) disable iff (!rstn)
      (req.wr && sel_mask && wcount == 4'h4 && !four_ok && !soft_reset_reg) |=> rsp.value_error;
   endproperty
   a_four_rule: assert property (p_four_rule) else $error("bad four mask accepted");

   property p_defaults_after;
      @(posedge ref_clk) disable iff (!rstn)
      soft_reset_reg |=> (mask_reg == `CHAN_MASK_DEFAULT && count_reg == `CHAN_COUNT_DEFAULT
      && run_channel_mask == `CHAN_MASK_DEFAULT && run_channel_count == `CHAN_COUNT_DEFAULT);
   endproperty
   a_defaults_after: assert property (p_defaults_after) else $error("settings not defaulted");

   property p_memory_invalid;
      @(posedge ref_clk) disable iff (!rstn)
      soft_reset_reg |=> !memory_valid;
   endproperty
   a_memory_invalid: assert property (p_memory_invalid) else $error("memory still valid");

   property p_outputs_off;
      @(posedge ref_clk) disable iff (!rstn)
      soft_reset_reg |=> (!trig_out_enable && !clk_out_enable);
   endproperty
   a_outputs_off: assert property (p_outputs_off) else $error("outputs left on");

   property p_eight_gate;
      @(posedge ref_clk) disable iff (!rstn)
      ((req.wr && sel_mask && wcount == 4'h8 && req.wdata[31:8] == 24'h000000)
      && !soft_reset_reg) |=> (rsp.value_error == (INSTALLED_CHANNELS < 4'h8));
   endproperty
   a_eight_gate: assert property (p_eight_gate) else $error("eight channel gate wrong");

   property p_count_read;
      @(posedge ref_clk) disable iff (!rstn)
      (req.rd && sel_count && !soft_reset_reg)
      |=> (rsp.rdata == {28'h0000000, $past(count_reg)});
   endproperty
   a_count_read: assert property (p_count_read) else $error("count readback wrong");
endmodule : channel_enable_and_reset_regs

// [verif/tb_channel_enable_and_reset_regs.sv]
// Purpose: Self-checking bench for the channel control register bank.
// Assumes: Boards of eight, four and two installed channels; one access every three cycles.
// Notes: The mask sweep walks every byte value, so each legal and illegal pattern is seen.
`timescale 1ns/1ps
`include "chan_regs_params.svh"
module tb_channel_enable_and_reset_regs;
   logic ref_clk;
   logic rstn;
   chan_regs_pkg::reg_req_s req;
   chan_regs_pkg::reg_rsp_s rsp;
   logic run_start, memory_written, trig_out_request, clk_out_request;
   logic [7:0] run_channel_mask;
   logic [3:0] run_channel_count;
   logic memory_valid, trig_out_enable, clk_out_enable;
   logic [31:0] rd_data;
   logic verr;
   chan_regs_pkg::reg_rsp_s rsp_four;
   chan_regs_pkg::reg_rsp_s rsp_two;
   logic [31:0] rd_four;
   logic [31:0] rd_two;
   logic verr_four;
   logic verr_two;
   int n_fail = 0;
   int total_checks = 0;
   channel_enable_and_reset_regs uut (.ref_clk(ref_clk), .rstn(rstn), .req(req), .rsp(rsp),
      .run_start(run_start), .run_channel_mask(run_channel_mask),
      .run_channel_count(run_channel_count), .memory_valid(memory_valid),
      .trig_out_enable(trig_out_enable), .clk_out_enable(clk_out_enable),
      .memory_written(memory_written), .trig_out_request(trig_out_request),
      .clk_out_request(clk_out_request));
   // Smaller boards take the same traffic; only their register answers are judged.
   channel_enable_and_reset_regs #(.INSTALLED_CHANNELS(4'h4)) uut_four (.ref_clk(ref_clk),
      .rstn(rstn), .req(req), .rsp(rsp_four), .run_start(run_start), .run_channel_mask(),
      .run_channel_count(), .memory_valid(), .trig_out_enable(), .clk_out_enable(),
      .memory_written(memory_written), .trig_out_request(trig_out_request),
      .clk_out_request(clk_out_request));
   channel_enable_and_reset_regs #(.INSTALLED_CHANNELS(4'h2)) uut_two (.ref_clk(ref_clk),
      .rstn(rstn), .req(req), .rsp(rsp_two), .run_start(run_start), .run_channel_mask(),
      .run_channel_count(), .memory_valid(), .trig_out_enable(), .clk_out_enable(),
      .memory_written(memory_written), .trig_out_request(trig_out_request),
      .clk_out_request(clk_out_request));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Fixed one-cycle answer, so the strobe drops at the edge that takes it.
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge ref_clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      check({31'h0, rsp.ack}, 32'h1);
      rd_data = rsp.rdata;
      verr = rsp.value_error;
      rd_four = rsp_four.rdata;
      rd_two = rsp_two.rdata;
      verr_four = rsp_four.value_error;
      verr_two = rsp_two.value_error;
   endtask : bus
   function automatic int ones(input logic [7:0] m);
      int c;
      c = 0;
      for (int i = 0; i < 8; i++) c += m[i];
      return c;
   endfunction : ones
   function automatic logic legal(input logic [7:0] m, input int n);
      int c;
      int lo;
      c = ones(m);
      lo = ones({4'h0, m[3:0]});
      if ((m >> n) != 8'h00) return 1'b0;
      return c == 1 || c == 2 || (c == 8 && n == 8)
         || (c == 4 && n >= 4 && lo != 1 && lo != 3);
   endfunction : legal
   task read_mask_count(input logic [7:0] m, input logic [7:0] m4, input logic [7:0] m2);
      bus(1'b0, `REG_CHANNEL_ENABLE_MASK, 32'h0);
      check(rd_data, {24'h0, m});
      check(rd_four, {24'h0, m4});
      check(rd_two, {24'h0, m2});
      bus(1'b0, `REG_ENABLED_CHANNEL_COUNT, 32'h0);
      check(rd_data, 32'(ones(m)));
      check(rd_four, 32'(ones(m4)));
      check(rd_two, 32'(ones(m2)));
   endtask : read_mask_count
   task test_sweep;
      logic [7:0] keep;
      logic [7:0] keep_four;
      logic [7:0] keep_two;
      keep = 8'h01;
      keep_four = 8'h01;
      keep_two = 8'h01;
      for (int m = 0; m < 256; m++) begin
         bus(1'b1, `REG_CHANNEL_ENABLE_MASK, 32'(m));
         check({31'h0, verr}, {31'h0, !legal(8'(m), 8)});
         check({31'h0, verr_four}, {31'h0, !legal(8'(m), 4)});
         check({31'h0, verr_two}, {31'h0, !legal(8'(m), 2)});
         if (legal(8'(m), 8)) keep = 8'(m);
         if (legal(8'(m), 4)) keep_four = 8'(m);
         if (legal(8'(m), 2)) keep_two = 8'(m);
         read_mask_count(keep, keep_four, keep_two);
      end
      bus(1'b1, `REG_CHANNEL_ENABLE_MASK, 32'h0000_0103);
      check({31'h0, verr}, 32'h1);
      read_mask_count(8'hff, keep_four, keep_two);
   endtask : test_sweep
   task pulse_run(input logic [7:0] m);
      @(posedge ref_clk);
      run_start <= 1'b1;
      @(posedge ref_clk);
      run_start <= 1'b0;
      @(posedge ref_clk);
      check({20'h0, run_channel_mask, run_channel_count}, {20'h0, m, 4'(ones(m))});
   endtask : pulse_run
   task test_next_run;
      pulse_run(8'hff);
      bus(1'b1, `REG_CHANNEL_ENABLE_MASK, 32'(8'h01 | 8'h02));
      check({24'h0, run_channel_mask}, 32'h0000_00ff);
      pulse_run(8'h03);
   endtask : test_next_run
   task test_card_reset;
      @(posedge ref_clk);
      {memory_written, trig_out_request, clk_out_request} <= 3'b111;
      @(posedge ref_clk);
      memory_written <= 1'b0;
      @(posedge ref_clk);
      #1 check({29'h0, memory_valid, trig_out_enable, clk_out_enable}, 32'h7);
      bus(1'b1, `REG_BOARD_COMMAND, `CARD_RESET_COMMAND);
      // Judged right after the reset edge, before the still-high requests come back.
      #1 check({29'h0, memory_valid, trig_out_enable, clk_out_enable}, 32'h0);
      @(posedge ref_clk);
      {trig_out_request, clk_out_request} <= 2'b00;
      read_mask_count(`CHAN_MASK_DEFAULT, `CHAN_MASK_DEFAULT, `CHAN_MASK_DEFAULT);
      check({20'h0, run_channel_mask, run_channel_count}, 32'h0000_0011);
      bus(1'b0, `REG_BOARD_COMMAND, 32'h0);
      check(rd_data, 32'h0);
      bus(1'b0, 32'h0000_0065, 32'h0);
      check(rd_data, 32'h0);
   endtask : test_card_reset
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   initial begin
      #400000;
      n_fail++;
      stop_test();
   end
   initial begin
      rstn = 1'b0;
      req = '0;
      {run_start, memory_written, trig_out_request, clk_out_request} = 4'h0;
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      bus(1'b1, `REG_BOARD_COMMAND, `CARD_RESET_COMMAND);
      read_mask_count(`CHAN_MASK_DEFAULT, `CHAN_MASK_DEFAULT, `CHAN_MASK_DEFAULT);
      test_sweep();
      test_next_run();
      test_card_reset();
      stop_test();
   end
endmodule : tb_channel_enable_and_reset_regs
